/* src/mopo_consts.vh */
// Command codes, field positions, reset values and ADC resolution codes for the option and strap-mask block
`ifndef MOPO_CONSTS_VH
`define MOPO_CONSTS_VH

// Command codes of the two configuration words
`define MOPO_CMD_MISC 8'hED
`define MOPO_CMD_PRIO 8'hEE

// Option word field positions
`define MOPO_PEC_BIT 15
`define MOPO_RLD_SHDN_BIT 14
`define MOPO_RLD_FLT_BIT 13
`define MOPO_PIN_FN_BIT 12
`define MOPO_PULLUP_N_BIT 3
`define MOPO_FCNT_MODE_BIT 2
`define MOPO_ADC_HI 1
`define MOPO_ADC_LO 0

// Priority mask field positions
`define MOPO_PRIO_STACK 12
`define MOPO_PRIO_SYNC 11
`define MOPO_PRIO_COMP 9
`define MOPO_PRIO_ADDR 8
`define MOPO_PRIO_PHASE 5
`define MOPO_PRIO_TON 3
`define MOPO_PRIO_IOC 2
`define MOPO_PRIO_FREQ 1
`define MOPO_PRIO_VOUT 0

// Reset values used until the stored image is loaded
`define MOPO_MISC_RESET 16'h0000
`define MOPO_PRIO_RESET 16'h0000

// ADC resolution codes
`define MOPO_ADC_12 2'h0
`define MOPO_ADC_10 2'h1
`define MOPO_ADC_8 2'h2
`define MOPO_ADC_6 2'h3

`endif

/* src/mopo_setting_pick.v */
// One setting selector: strap value or stored value, by priority mask bit
`timescale 1ns/10ps
`default_nettype none

module mopo_setting_pick #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire load_i,
    input wire strap_wins_i,
    input wire [WIDTH-1:0] strap_val_i,
    input wire [WIDTH-1:0] stored_val_i,
    output reg [WIDTH-1:0] value_o
);

    // Load the chosen source on power-up or restore
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            value_o <= {WIDTH{1'b0}};
        end else if (load_i) begin
            value_o <= strap_wins_i ? strap_val_i : stored_val_i;
        end
    end

endmodule
`default_nettype wire

/* src/mopo_option_regs.v */
// Miscellaneous option word and strap priority mask with their effects
//
// Overview of operation
// - PEC clear: accept frames without PEC
// - PEC set: missing PEC treated as mismatch
// - Shutdown reloads setpoint with boot voltage if set
// - Fault retry restart reloads setpoint if set
// - Pin function: power good or reset
// - Reset mode: pull-up enabled when bit clear
// - Mode clear: counter decrements per clean cycle
// - Mode set: counter clears per clean cycle
// - ADC code maps to 12/10/8/6 bits
// - Both words use word write and read
// - Writes immediate; straps sampled only at POR
// - Mask one keeps strapped setting
// - Mask zero loads stored; bit 5 phase
// - Bits 12,11,9,8: stack, sync, comp, address
// - Bits 3,2,1,0: rise, current, freq, output
`timescale 1ns/10ps
`default_nettype none
`include "mopo_consts.vh"

module mopo_option_regs #(
    parameter FCNT_WIDTH = 8,
    parameter SET_WIDTH = 8,
    parameter VOUT_WIDTH = 16
) (
    input wire clk_i,
    input wire reset_n_i,
    // Decoded management bus word transaction
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire cmd_word_i,
    input wire [7:0] cmd_code_i,
    input wire [15:0] cmd_wdata_i,
    input wire pec_present_i,
    input wire pec_ok_i,
    output reg cmd_exec_o,
    output reg cmd_pec_err_o,
    output reg cmd_ack_o,
    output reg [15:0] cmd_rdata_o,
    // Stored image load at power-up or restore
    input wire nvm_load_i,
    input wire [15:0] nvm_misc_i,
    input wire [15:0] nvm_prio_i,
    // Strap inputs, one vector of settings
    input wire [SET_WIDTH*9-1:0] strap_set_i,
    input wire [SET_WIDTH*9-1:0] stored_set_i,
    output reg [SET_WIDTH*9-1:0] active_set_o,
    // Output setpoint handling
    input wire shutdown_ctrl_i,
    input wire fault_restart_i,
    input wire fault_retry_mode_i,
    input wire setpoint_wr_i,
    input wire [VOUT_WIDTH-1:0] setpoint_wdata_i,
    input wire [VOUT_WIDTH-1:0] boot_voltage_i,
    output reg [VOUT_WIDTH-1:0] setpoint_o,
    // Fault counter
    input wire pwm_cycle_i,
    input wire fault_i,
    output reg [FCNT_WIDTH-1:0] fault_count_o,
    // Shared status pin
    input wire power_good_i,
    input wire reset_out_n_i,
    output reg shared_status_pin_o,
    output reg shared_status_pin_oe_o,
    output reg pullup_en_o,
    output reg [3:0] adc_bits_o
);

    localparam NSET = 9; // Settings under strap priority

    // Option word layout
    // 15: Check byte required on every frame
    // 14: Setpoint reload on commanded shutdown
    // 13: Setpoint reload on fault retry restart
    // 12: Status pin carries reset output
    // 11:4: Reserved, kept as written
    // 3: Pull-up off while in reset mode
    // 2: Clean cycle clears fault counter
    // 1:0: Converter resolution code
    //
    // Priority mask layout, a one keeps the strap
    // 15:13: Unused, kept as written
    // 12: Phase stack setting
    // 11: Sync setting
    // 10: Reserved, kept as written
    // 9: Loop compensation setting
    // 8: Bus device address
    // 7:6: Unused, kept as written
    // 5: Phase offset setting
    // 4: Reserved, kept as written
    // 3: Output rise time
    // 2: Both overcurrent limits
    // 1: Switching frequency
    // 0: Output voltage group
    // Stored words and internal state
    reg [15:0] misc_option_word; // Option word
    reg [15:0] pin_strap_priority_mask;
    reg por_done; // Straps captured once after POR
    reg load_pend; // Load request for pickers
    reg [SET_WIDTH*9-1:0] strap_latch; // Straps held since POR
    reg [FCNT_WIDTH-1:0] next_fault_count;
    reg [3:0] next_adc_bits;
    wire [NSET-1:0] prio_sel; // Priority bit per setting
    wire [SET_WIDTH*9-1:0] picked;
    wire access_ok;
    wire is_misc;
    wire is_prio;
    // Field views of the option word
    wire pec_required; // Every frame needs a check byte
    wire setpoint_reload_on_shutdown; // Boot value on shutdown
    wire setpoint_reload_on_fault_retry; // Boot value on retry
    wire reset_pin_mode; // Status pin acts as reset
    wire pullup_off; // Pull-up off in reset mode
    wire fault_counter_mode; // Clean cycle clears counter
    wire [1:0] adc_resolution_select; // Resolution code

    // Setting order: vout, freq, ioc, ton, phase, addr, comp, sync, stack
    assign prio_sel = {pin_strap_priority_mask[`MOPO_PRIO_STACK],
                       pin_strap_priority_mask[`MOPO_PRIO_SYNC],
                       pin_strap_priority_mask[`MOPO_PRIO_COMP],
                       pin_strap_priority_mask[`MOPO_PRIO_ADDR],
                       pin_strap_priority_mask[`MOPO_PRIO_PHASE],
                       pin_strap_priority_mask[`MOPO_PRIO_TON],
                       pin_strap_priority_mask[`MOPO_PRIO_IOC],
                       pin_strap_priority_mask[`MOPO_PRIO_FREQ],
                       pin_strap_priority_mask[`MOPO_PRIO_VOUT]};

    // Missing PEC passes only when not required; bad PEC always fails
    assign access_ok = pec_present_i ? pec_ok_i
                     : ~pec_required;
    assign is_misc = (cmd_code_i == `MOPO_CMD_MISC);
    assign is_prio = (cmd_code_i == `MOPO_CMD_PRIO);

    // Option word fields by name
    assign pec_required = misc_option_word[`MOPO_PEC_BIT];
    assign setpoint_reload_on_shutdown = misc_option_word[`MOPO_RLD_SHDN_BIT];
    assign setpoint_reload_on_fault_retry = misc_option_word[`MOPO_RLD_FLT_BIT];
    assign reset_pin_mode = misc_option_word[`MOPO_PIN_FN_BIT];
    assign pullup_off = misc_option_word[`MOPO_PULLUP_N_BIT];
    assign fault_counter_mode = misc_option_word[`MOPO_FCNT_MODE_BIT];
    assign adc_resolution_select = misc_option_word[`MOPO_ADC_HI:`MOPO_ADC_LO];

    // Register writes and reads, word transactions only
    // Request taken at one edge, answer pulses one cycle later
    // Stored image load wins over a bus write in the same cycle
    // Refused frames still answer, with the check error pulse
    // Non-word frames answer but change nothing
    // Codes other than the two words get no answer
    // Read data holds until the next accepted read
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            misc_option_word <= `MOPO_MISC_RESET;
            pin_strap_priority_mask <= `MOPO_PRIO_RESET;
            cmd_exec_o <= 1'b0;
            cmd_pec_err_o <= 1'b0;
            cmd_ack_o <= 1'b0;
            cmd_rdata_o <= 16'h0000;
        end else begin
            cmd_exec_o <= 1'b0;
            cmd_pec_err_o <= 1'b0;
            cmd_ack_o <= 1'b0;
            if (nvm_load_i) begin
                // Stored image replaces both words
                misc_option_word <= nvm_misc_i;
                pin_strap_priority_mask <= nvm_prio_i;
            end else if (cmd_valid_i && (is_misc || is_prio)) begin
                cmd_ack_o <= 1'b1;
                if (!access_ok) begin
                    // Rejected as invalid PEC
                    cmd_pec_err_o <= 1'b1;
                end else if (cmd_word_i) begin
                    cmd_exec_o <= 1'b1;
                    if (cmd_write_i) begin
                        // Whole word kept, reserved bits too
                        if (is_misc) begin
                            misc_option_word <= cmd_wdata_i;
                        end else begin
                            pin_strap_priority_mask <= cmd_wdata_i;
                        end
                    end else begin
                        cmd_rdata_o <= is_misc ? misc_option_word
                                               : pin_strap_priority_mask;
                    end
                end
            end
        end
    end

    // One-time strap capture just after POR release
    // Straps read at the first edge out of reset
    // Later strap changes are ignored until the next POR
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            por_done <= 1'b0;
            strap_latch <= {SET_WIDTH*9{1'b0}};
        end else if (!por_done) begin
            por_done <= 1'b1;
            strap_latch <= strap_set_i;
        end
    end

    // Pickers load at first stored-image load and every restore
    // Load sequence, counted from the edge taking the load:
    // edge 0 copies both stored words into the registers,
    // edge 1 lets the pickers choose with the new mask,
    // edge 2 shows the chosen settings on the outputs
    // One cycle behind the load so the new mask is in place
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            load_pend <= 1'b0;
        end else begin
            load_pend <= nvm_load_i;
        end
    end

    // One picker per maskable setting
    // A set mask bit keeps the strap; a clear bit takes the image
    // Vector order follows the prio_sel order above
    genvar gi;
    generate
        for (gi = 0; gi < NSET; gi = gi + 1) begin : g_pick
            mopo_setting_pick #(
                .WIDTH(SET_WIDTH)
            ) u_pick (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .load_i(load_pend),
                .strap_wins_i(prio_sel[gi]),
                .strap_val_i(strap_latch[gi*SET_WIDTH +: SET_WIDTH]),
                .stored_val_i(stored_set_i[gi*SET_WIDTH +: SET_WIDTH]),
                .value_o(picked[gi*SET_WIDTH +: SET_WIDTH])
            );
        end
    endgenerate

    // Register the picked settings for output
    // One edge behind the pickers, straight from a flip-flop
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            active_set_o <= {SET_WIDTH*9{1'b0}};
        end else begin
            active_set_o <= picked;
        end
    end

    // Output setpoint: host write, shutdown or fault reload
    // Shutdown reload wins over fault reload over host write
    // A clear reload bit keeps the present setpoint
    // Host writes land only when no reload is due
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            setpoint_o <= {VOUT_WIDTH{1'b0}};
        end else if (shutdown_ctrl_i && setpoint_reload_on_shutdown) begin
            setpoint_o <= boot_voltage_i;
        end else if (fault_restart_i && fault_retry_mode_i
                     && setpoint_reload_on_fault_retry) begin
            setpoint_o <= boot_voltage_i;
        end else if (setpoint_wr_i) begin
            setpoint_o <= setpoint_wdata_i;
        end
    end

    // Fault counter next value
    // Faulted cycle counts up and saturates at all ones
    // Clean cycle counts down to zero or clears, by mode
    // No change on edges without a PWM cycle
    always @* begin
        next_fault_count = fault_count_o;
        if (pwm_cycle_i) begin
            if (fault_i) begin
                // Count up, saturating
                if (fault_count_o != {FCNT_WIDTH{1'b1}}) begin
                    next_fault_count = fault_count_o + {{(FCNT_WIDTH-1){1'b0}}, 1'b1};
                end
            end else if (fault_counter_mode) begin
                next_fault_count = {FCNT_WIDTH{1'b0}};
            end else if (fault_count_o != {FCNT_WIDTH{1'b0}}) begin
                next_fault_count = fault_count_o - {{(FCNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Fault counter register
    // Updated on every edge; holds outside PWM cycles
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            fault_count_o <= {FCNT_WIDTH{1'b0}};
        end else begin
            fault_count_o <= next_fault_count;
        end
    end

    // ADC resolution decode
    // Output is the converter width in bits
    // Default keeps full width for safety
    always @* begin
        case (adc_resolution_select)
            `MOPO_ADC_12: next_adc_bits = 4'hC;
            `MOPO_ADC_10: next_adc_bits = 4'hA;
            `MOPO_ADC_8: next_adc_bits = 4'h8;
            `MOPO_ADC_6: next_adc_bits = 4'h6;
            default: next_adc_bits = 4'hC;
        endcase
    end

    // Resolution register, one edge behind the word
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            adc_bits_o <= 4'hC;
        end else begin
            adc_bits_o <= next_adc_bits;
        end
    end

    // Shared status pin function and pull-up
    // Pin is always driven, so the enable stays high
    // Power good mode leaves the internal pull-up off
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            shared_status_pin_o <= 1'b0;
            shared_status_pin_oe_o <= 1'b1;
            pullup_en_o <= 1'b0;
        end else begin
            shared_status_pin_oe_o <= 1'b1;
            if (reset_pin_mode) begin
                // Active-low reset output
                shared_status_pin_o <= reset_out_n_i;
                pullup_en_o <= ~pullup_off;
            end else begin
                // Power good, no internal pull-up
                shared_status_pin_o <= power_good_i;
                pullup_en_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* tb/mopo_host.sv */
// Management bus host model issuing whole word transfers
`timescale 1ns/10ps
`default_nettype none
module mopo_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic exec_i,
    input wire logic err_i,
    input wire logic [15:0] rdata_i,
    output logic valid_o,
    output logic write_o,
    output logic [7:0] code_o,
    output logic [15:0] wdata_o,
    output logic pec_o,
    output logic pec_ok_o
);
    // Idle bus at time zero
    initial begin
        {valid_o, write_o, pec_o, pec_ok_o} = 4'h0;
        code_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // One word transfer; answer taken in the cycle after the request
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
        input logic p, input logic k, output logic [2:0] res, output logic [15:0] rd);
        @(posedge clk_i);
        valid_o <= 1'b1;
        write_o <= wr;
        code_o <= c;
        wdata_o <= d & ((c == 8'hED) ? 16'hF00F : 16'h1F3F);
        pec_o <= p;
        pec_ok_o <= k;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // Released lines show a changed value, not the last one
        wdata_o <= ~wdata_o;
        pec_ok_o <= ~k;
        @(negedge clk_i);
        res = {ack_i, exec_i, err_i};
        rd = rdata_i;
    endtask
endmodule
`default_nettype wire

/* tb/mopo_regs_chk.sv */
// Checker for bus answers and option word effects
`timescale 1ns/10ps
`default_nettype none
module mopo_regs_chk #(
    parameter FCNT_WIDTH = 8,
    parameter VOUT_WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_word_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic pec_present_i,
    input wire logic pec_ok_i,
    input wire logic nvm_load_i,
    input wire logic cmd_exec_o,
    input wire logic cmd_pec_err_o,
    input wire logic cmd_ack_o,
    input wire logic shutdown_ctrl_i,
    input wire logic fault_restart_i,
    input wire logic fault_retry_mode_i,
    input wire logic setpoint_wr_i,
    input wire logic [VOUT_WIDTH-1:0] boot_voltage_i,
    input wire logic [VOUT_WIDTH-1:0] setpoint_o,
    input wire logic pwm_cycle_i,
    input wire logic fault_i,
    input wire logic [FCNT_WIDTH-1:0] fault_count_o,
    input wire logic pullup_en_o,
    input wire logic [3:0] adc_bits_o
);
    logic [15:0] opt, opt_d; // Option word mirror and its one edge late copy
    logic hit; // Accepted option word write
    assign hit = cmd_valid_i && cmd_write_i && cmd_word_i && !nvm_load_i
        && cmd_code_i == 8'hED && (pec_present_i ? pec_ok_i : !opt[15]);
    // Mirror follows accepted writes
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            opt <= 16'h0000;
            opt_d <= 16'h0000;
        end else begin
            if (hit) begin
                opt <= cmd_wdata_i;
            end
            opt_d <= opt;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_take;
        cmd_valid_i && cmd_word_i && !nvm_load_i && cmd_code_i inside {8'hED, 8'hEE};
    endsequence
    sequence s_bare_wr;
        cmd_write_i && !pec_present_i;
    endsequence
    a_pec_refuse: assert property (s_take ##0 s_bare_wr ##0 opt[15]
        |=> cmd_pec_err_o && !cmd_exec_o) else $error("missing check byte not refused");
    a_pec_optional: assert property (s_take ##0 s_bare_wr ##0 !opt[15]
        |=> cmd_exec_o && !cmd_pec_err_o) else $error("bare write not executed");
    a_word_answer: assert property (s_take |=> cmd_ack_o) else $error("no answer");
    a_shdn_reload: assert property (shutdown_ctrl_i && opt[14]
        |=> setpoint_o == $past(boot_voltage_i)) else $error("shutdown reload missed");
    a_shdn_keep: assert property (shutdown_ctrl_i && !opt[14] && !fault_restart_i
        && !setpoint_wr_i |=> $stable(setpoint_o)) else $error("setpoint changed");
    a_flt_reload: assert property (fault_restart_i && fault_retry_mode_i && opt[13]
        && !shutdown_ctrl_i |=> setpoint_o == $past(boot_voltage_i)) else $error("retry reload");
    a_fcnt_dec: assert property (pwm_cycle_i && !fault_i && !opt[2] && fault_count_o != '0
        |=> fault_count_o == $past(fault_count_o) - 1'b1) else $error("count not decremented");
    a_fcnt_clear: assert property (pwm_cycle_i && !fault_i && opt[2]
        |=> fault_count_o == '0) else $error("count not cleared");
    a_pullup_sel: assert property (pullup_en_o == (opt_d[12] && !opt_d[3]))
        else $error("pull-up select wrong");
    a_adc_map: assert property (adc_bits_o == 4'hC - {1'b0, opt_d[1:0], 1'b0})
        else $error("resolution map wrong");
endmodule
`default_nettype wire

/* tb/tb_misc_option_word_pin_override_regs.sv */
// Top testbench for the option word and strap priority block
`timescale 1ns/10ps
`default_nettype none
module tb_misc_option_word_pin_override_regs;
    logic clk = 1'b0, rst_n = 1'b0, nvm_ld = 1'b0, shdn = 1'b0, frst = 1'b0, fretry = 1'b0;
    logic spwr = 1'b0, pwm = 1'b0, flt = 1'b0, valid, wr, pp, pok, ack, ex, perr, oe, pin, pu;
    logic pg = 1'b0, rso_n = 1'b1; // Status pin sources
    logic [15:0] prio = 16'h0000, wd, rdata, sp, rd;
    logic [71:0] strap = {9{8'hA5}}, stored = {9{8'h3C}}, act;
    logic [7:0] code, fcnt;
    logic [3:0] adc;
    logic [2:0] res;
    int err_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    mopo_option_regs uut (.clk_i(clk), .reset_n_i(rst_n), .cmd_valid_i(valid),
        .cmd_write_i(wr), .cmd_word_i(1'b1), .cmd_code_i(code), .cmd_wdata_i(wd),
        .pec_present_i(pp), .pec_ok_i(pok), .cmd_exec_o(ex), .cmd_pec_err_o(perr),
        .cmd_ack_o(ack), .cmd_rdata_o(rdata), .nvm_load_i(nvm_ld), .nvm_misc_i(16'h0000),
        .nvm_prio_i(prio), .strap_set_i(strap), .stored_set_i(stored), .active_set_o(act),
        .shutdown_ctrl_i(shdn), .fault_restart_i(frst), .fault_retry_mode_i(fretry),
        .setpoint_wr_i(spwr), .setpoint_wdata_i(16'h1234), .boot_voltage_i(16'h0600),
        .setpoint_o(sp), .pwm_cycle_i(pwm), .fault_i(flt), .fault_count_o(fcnt),
        .power_good_i(pg), .reset_out_n_i(rso_n), .shared_status_pin_o(pin),
        .shared_status_pin_oe_o(oe), .pullup_en_o(pu), .adc_bits_o(adc));
    mopo_host host (.clk_i(clk), .ack_i(ack), .exec_i(ex), .err_i(perr), .rdata_i(rdata),
        .valid_o(valid), .write_o(wr), .code_o(code), .wdata_o(wd), .pec_o(pp), .pec_ok_o(pok));
    // Compare and count
    task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One PWM cycle with or without a fault
    task automatic tick(input logic f);
        @(posedge clk);
        pwm <= 1'b1;
        flt <= f;
        @(posedge clk);
        pwm <= 1'b0;
        flt <= 1'b0;
    endtask
    // Pulse: 0 setpoint write, 1 shutdown, 2 fault restart
    task automatic pulse(input int k, input logic r);
        @(posedge clk);
        {spwr, shdn, frst} <= {k == 0, k == 1, k == 2};
        fretry <= r;
        @(posedge clk);
        {spwr, shdn, frst} <= 3'b000;
        @(negedge clk);
    endtask
    // Values after reset
    task automatic t_reset;
        @(negedge clk);
        chk("reset outputs", 72'h32000000, 72'({adc, oe, pu, fcnt, sp})); // RESET
        host.xfer(1'b0, 8'hED, 16'h0000, 1'b0, 1'b0, res, rd);
        chk("option word", 72'h0, 72'(rd)); // RESET
        $display("t_reset done");
    endtask
    // Stored image load against captured straps, both mask polarities
    task automatic t_strap;
        logic [15:0] m[2] = '{16'h0921, 16'h120E};
        logic [71:0] e[2] = '{72'h3CA53CA5A53C3C3CA5, 72'hA53CA53C3CA5A5A53C};
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            strap <= 72'h0;
            prio <= m[i];
            nvm_ld <= 1'b1;
            @(posedge clk);
            nvm_ld <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("active settings", e[i], act);
            host.xfer(1'b0, 8'hEE, 16'h0000, 1'b0, 1'b0, res, rd);
            chk("mask read", 72'({3'h6, m[i]}), 72'({res, rd}));
        end
        $display("t_strap done");
    endtask
    // Check byte policy, then pin function and resolution table
    task automatic t_opt;
        logic [15:0] w[4] = '{16'h0000, 16'h1001, 16'h100A, 16'h000B};
        logic [5:0] e[4] = '{6'h30, 6'h2A, 6'h21, 6'h19};
        host.xfer(1'b1, 8'hED, 16'h0003, 1'b0, 1'b0, res, rd);
        chk("bare write", 72'h6, 72'(res));
        host.xfer(1'b1, 8'hED, 16'h8002, 1'b1, 1'b1, res, rd);
        chk("checked write", 72'h6, 72'(res));
        host.xfer(1'b1, 8'hED, 16'h0001, 1'b0, 1'b0, res, rd);
        chk("bare refused", 72'h5, 72'(res));
        host.xfer(1'b1, 8'hED, 16'h0001, 1'b1, 1'b0, res, rd);
        chk("bad refused", 72'h5, 72'(res));
        host.xfer(1'b0, 8'hED, 16'h0000, 1'b1, 1'b1, res, rd);
        chk("word kept", 72'h8002, 72'(rd));
        host.xfer(1'b1, 8'hEC, 16'h0000, 1'b1, 1'b1, res, rd);
        chk("other code", 72'h0, 72'(res));
        host.xfer(1'b1, 8'hEE, 16'h1F3F, 1'b1, 1'b1, res, rd);
        host.xfer(1'b0, 8'hEE, 16'h0000, 1'b1, 1'b1, res, rd);
        chk("reserved kept", 72'h61F3F, 72'({res, rd}));
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pg <= i[0];
            rso_n <= !i[0];
            host.xfer(1'b1, 8'hED, w[i], 1'b1, 1'b1, res, rd);
            @(negedge clk);
            chk("adc, pull-up and pin", 72'(e[i]), 72'({adc, pu, pin}));
        end
        $display("t_opt done");
    endtask
    // Fault counter in both modes
    task automatic t_fcnt;
        host.xfer(1'b1, 8'hED, 16'h0000, 1'b0, 1'b0, res, rd);
        repeat (3) tick(1'b1);
        tick(1'b0);
        @(negedge clk);
        chk("count down", 72'h2, 72'(fcnt));
        host.xfer(1'b1, 8'hED, 16'h0004, 1'b0, 1'b0, res, rd);
        tick(1'b1);
        tick(1'b0);
        @(negedge clk);
        chk("count clear", 72'h0, 72'(fcnt));
        $display("t_fcnt done");
    endtask
    // Setpoint reload on shutdown and fault retry
    task automatic t_sp;
        logic [15:0] w[5] = '{16'h0000, 16'h0000, 16'h4000, 16'h2000, 16'h2000};
        logic r[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        int k[5] = '{1, 2, 1, 2, 2};
        logic [15:0] e[5] = '{16'h1234, 16'h1234, 16'h0600, 16'h1234, 16'h0600};
        for (int i = 0; i < 5; i++) begin
            host.xfer(1'b1, 8'hED, w[i], 1'b0, 1'b0, res, rd);
            pulse(0, r[i]);
            pulse(k[i], r[i]);
            chk("setpoint", 72'(e[i]), 72'(sp));
        end
        $display("t_sp done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_strap;
        t_opt;
        t_fcnt;
        t_sp;
        finish_test;
    end
endmodule
bind mopo_option_regs mopo_regs_chk #(.FCNT_WIDTH(FCNT_WIDTH), .VOUT_WIDTH(VOUT_WIDTH)) chk_i (.*);
`default_nettype wire
